// file: dv/drive_model.sv
`timescale 1ns/1ps
module drive_model (
	input wire logic ref_clk,
	output result_status_pkg::drive_lines_t pins
);
	import result_status_pkg::*;
	drive_lines_t line_state = '0;
	// Drive lines move just after a clock edge, as a real drive's would not care
	task automatic set_lines(input drive_lines_t v);
		@(posedge ref_clk);
		line_state <= v;
	endtask
	assign pins = line_state;
endmodule // drive_model

// file: dv/result_status_props.sv
`timescale 1ns/1ps
module result_status_props (
	input wire logic ref_clk,
	input wire logic nrst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire result_status_pkg::drive_select_t drive_select,
	input wire result_status_pkg::seq_events_t events,
	input wire logic result_ready,
	input wire logic irq_event
);
	import result_status_pkg::*;
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!nrst);
	logic rd_acc;
	assign rd_acc = psel && penable && !pwrite;
	AST_DONE_IRQ: assert property (events.cmd_done |=> irq_event && result_ready)
		else $error("no interrupt after completion");
	AST_IRQ_CAUSE: assert property (irq_event |-> $past(events.cmd_done) || $past(events.cmd_abort))
		else $error("interrupt without completion");
	AST_INVALID_QUIET: assert property (events.cmd_invalid && !events.cmd_done
		&& !events.cmd_abort |=> !irq_event && result_ready)
		else $error("invalid command raised interrupt");
	AST_SR1_UNUSED: assert property (rd_acc && paddr == addr_transfer_error
		|-> prdata[6] == 1'b0 && prdata[3] == 1'b0)
		else $error("unused transfer bits set");
	AST_SR2_UNUSED: assert property (rd_acc && paddr == addr_data_field |-> prdata[7] == 1'b0)
		else $error("unused data field bit set");
	AST_SR3_SELECT: assert property (rd_acc && paddr == addr_drive_line && $stable(drive_select)
		|-> prdata[2:0] == $past(drive_select))
		else $error("select lines not mirrored");
	AST_UPPER_ZERO: assert property (rd_acc |-> prdata[31:8] == 24'h000000)
		else $error("upper read bits set");
	AST_UNMAPPED: assert property (psel && penable && paddr > addr_outcome_ctrl
		|-> pslverr && prdata == 32'h00000000)
		else $error("unmapped access not refused");
	AST_ZERO_WAIT: assert property (psel && penable |-> pready)
		else $error("wait state inserted");
endmodule // result_status_props

// file: dv/tb.sv
`timescale 1ns/1ps
module tb;
	import result_status_pkg::*;
	logic ref_clk = 1'b0;
	logic nrst = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h00000000;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic result_ready;
	logic irq_event;
	drive_lines_t drive_pins;
	drive_select_t drive_select = '0;
	seq_events_t events = '0;
	seq_events_t lv = '0;
	int n_errors = 0;
	int total_checks = 0;
	always #10 ref_clk = ~ref_clk;
	drive_model drive (.ref_clk, .pins(drive_pins));
	disk_controller_result_status dut (.ref_clk, .nrst, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .drive_pins, .drive_select, .events,
		.result_ready, .irq_event);
	task automatic end_of_test;
		$display("checks %0d errors %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
		logic exp_err;
		exp_err = (a > addr_outcome_ctrl);
		psel <= 1'b1;
		pwrite <= 1'b0;
		paddr <= a;
		@(posedge ref_clk);
		penable <= 1'b1;
		do @(posedge ref_clk); while (pready !== 1'b1);
		total_checks++;
		if (prdata !== {24'h000000, exp}) begin
			n_errors++;
			$display("mismatch %s expected %h seen %h", what, exp, prdata);
		end
		total_checks++;
		if (pslverr !== exp_err) begin
			n_errors++;
			$display("mismatch pslverr %s expected %b seen %b", what, exp_err, pslverr);
		end
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge ref_clk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= 1'b1;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		do @(posedge ref_clk); while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
		pwrite <= 1'b0;
		@(posedge ref_clk);
	endtask
	task automatic fire(input seq_events_t p);
		events <= seq_events_t'(p | lv);
		@(posedge ref_clk);
		events <= lv;
		@(posedge ref_clk);
	endtask
	task automatic start_cmd;
		seq_events_t p;
		p = '0;
		p.cmd_start = 1'b1;
		fire(p);
	endtask
	task automatic end_cmd;
		seq_events_t p;
		p = '0;
		p.cmd_done = 1'b1;
		fire(p);
	endtask
	task automatic lines(input drive_lines_t v);
		drive.set_lines(v);
		repeat (4) @(posedge ref_clk);
	endtask
	task automatic t_invalid;
		seq_events_t p;
		p = '0;
		p.cmd_invalid = 1'b1;
		fire(p);
		rd(addr_command_result, 8'h80, "invalid");
	endtask
	task automatic t_seek;
		drive_select <= 3'b110;
		lv = '0;
		lv.is_seek = 1'b1;
		start_cmd;
		end_cmd;
		rd(addr_command_result, 8'h26, "seek");
	endtask
	task automatic t_err;
		seq_events_t p;
		lines(5'b01101);
		lv = '0;
		lv.is_rw = 1'b1;
		lv.requested_cylinder = 8'h05;
		lv.media_cylinder = bad_cylinder_value;
		start_cmd;
		p = '0;
		p.beyond_last_sector = 1'b1;
		p.id_crc_fault = 1'b1;
		p.data_crc_fault = 1'b1;
		p.overrun = 1'b1;
		p.sector_missing = 1'b1;
		p.media_cyl_valid = 1'b1;
		p.write_attempt = 1'b1;
		p.data_sync_missing = 1'b1;
		p.deleted_sector_seen = 1'b1;
		p.compare_equal_hit = 1'b1;
		p.compare_unmet = 1'b1;
		fire(p);
		end_cmd;
		rd(addr_transfer_error, 8'hb7, "transfer");
		rd(addr_data_field, 8'h7f, "data field");
		rd(addr_command_result, 8'h46, "abnormal");
	endtask
	task automatic t_recal;
		seq_events_t p;
		lv = '0;
		lv.is_recal = 1'b1;
		start_cmd;
		p = '0;
		p.recal_step = 1'b1;
		repeat (77) fire(p);
		end_cmd;
		rd(addr_command_result, 8'h76, "recal");
	endtask
	task automatic t_not_ready;
		lines(5'b00001);
		lv = '0;
		lv.is_rw = 1'b1;
		start_cmd;
		end_cmd;
		rd(addr_command_result, 8'h4e, "not ready");
	endtask
	task automatic t_lines;
		drive_select <= 3'b101;
		lines(5'b10011);
		rd(addr_drive_line, 8'h9d, "drive lines");
		rd(8'h20, 8'h00, "unmapped");
	endtask
	task automatic t_abort;
		seq_events_t p;
		lines(5'b00101);
		lv = '0;
		lv.is_rw = 1'b1;
		start_cmd;
		p = '0;
		p.cmd_abort = 1'b1;
		events <= seq_events_t'(p | lv);
		@(posedge ref_clk);
		events <= lv;
		@(negedge ref_clk);
		total_checks++;
		if (irq_event !== 1'b1 || result_ready !== 1'b1) begin
			n_errors++;
			$display("mismatch abort irq expected 1 seen %b", irq_event);
		end
		@(posedge ref_clk);
		rd(addr_command_result, 8'hc5, "abort");
		rd(addr_outcome_ctrl, 8'h01, "result ready");
		wr(addr_outcome_ctrl, 32'h00000001);
		rd(addr_outcome_ctrl, 8'h00, "result ready cleared");
	endtask
	initial begin
		repeat (5) @(posedge ref_clk);
		nrst <= 1'b1;
		lines(5'b00101);
		t_invalid;
		t_seek;
		t_err;
		t_recal;
		t_not_ready;
		t_lines;
		t_abort;
		end_of_test;
	end
	initial begin
		repeat (3000) @(posedge ref_clk);
		n_errors++;
		end_of_test;
	end
endmodule // tb
bind disk_controller_result_status result_status_props props (.ref_clk, .nrst, .psel, .penable,
	.pwrite, .paddr, .prdata, .pready, .pslverr, .drive_select, .events, .result_ready, .irq_event);

// file: rtl/disk_controller_result_status.sv
// Register access over APB and the address map are this design's own decisions.
`timescale 1ns/1ps
// Overview of operation
// - Top two bits of first register hold the termination code.
// - Bit 5 of first register set when a seek or recalibrate finishes.
// - Bit 4 set on drive fault or no home track after 77 steps.
// - Bit 3 set for read/write to unready drive or side 1 single-sided.
// - Bit 2 of first register holds selected side at interrupt time.
// - Bits 1:0 of first register hold unit number at interrupt time.
// - Bit 7 of second register set on access past final sector.
// - Unused bits 6,3 of second and bit 7 of third read zero.
// - Bit 5 of second register set on any CRC fault.
// - Bit 4 of second register set on service overrun.
// - Bit 2 of second register set when sector or ID not found.
// - Bit 1 of second register set on write to protected drive.
// - Bit 0 of second set on missing ID or data mark.
// - Bit 6 of third register set on deleted-data mark seen.
// - Bit 5 of third register set on data field CRC fault.
// - Bit 4 of third set with sector-missing on cylinder mismatch.
// - Bit 3 of third register set on scan equal hit.
// - Bit 2 of third register set when scan condition unmet.
// - Bit 1 of third set with sector-missing when media cylinder is FF.
// - Bit 0 of third register set on missing data mark.
// - Fourth register mirrors fault, protect, ready, home, two-sided lines.
// - Fourth register mirrors side select and unit select outputs.
// - Undefined command gives 80H in first register, no interrupt.
module disk_controller_result_status
	import result_status_pkg::*;
(
	input wire logic ref_clk,
	input wire logic nrst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire result_status_pkg::drive_lines_t drive_pins,
	input wire result_status_pkg::drive_select_t drive_select,
	input wire result_status_pkg::seq_events_t events,
	output logic result_ready,
	output logic irq_event
);
	import result_status_pkg::*;

	drive_lines_t lines;
	logic [7:0] cmd_res, xfer_err, data_fld, next_cmd_res, next_xfer_err, next_data_fld;
	logic [6:0] step_count, next_step_count;
	logic next_result_ready, next_irq_event;
	logic clear_req, next_clear_req;
	logic [31:0] next_prdata;
	logic access, mapped;

	line_sync #(.width(5)) u_sync (
		.ref_clk(ref_clk),
		.nrst(nrst),
		.raw(drive_pins),
		.clean(lines)
	);

	assign access = psel && penable;
	assign pready = 1'b1;
	assign mapped = (paddr == addr_command_result) || (paddr == addr_transfer_error) ||
		(paddr == addr_data_field) || (paddr == addr_drive_line) ||
		(paddr == addr_outcome_ctrl);
	assign pslverr = access && !mapped;

	// Result register update
	always_comb begin
		next_cmd_res = cmd_res;
		next_xfer_err = xfer_err;
		next_data_fld = data_fld;
		next_step_count = step_count;
		next_result_ready = result_ready;
		next_irq_event = 1'b0;
		next_clear_req = access && pwrite && (paddr == addr_outcome_ctrl) && pwdata[0];
		if (clear_req) begin
			next_result_ready = 1'b0;
		end
		if (events.cmd_start) begin
			next_cmd_res = status_reset;
			next_xfer_err = status_reset;
			next_data_fld = status_reset;
			next_step_count = '0;
			next_result_ready = 1'b0;
		end
		if (events.cmd_invalid) begin
			next_cmd_res = {term_invalid, 6'h00};
			next_result_ready = 1'b1;
		end else begin
			if (events.is_recal && events.recal_step && step_count != recal_step_limit) begin
				next_step_count = step_count + 7'h01;
			end
			if (lines.drive_fault_line && (events.is_rw || events.is_seek || events.is_recal)) begin
				next_cmd_res[pos_equipment_fault] = 1'b1;
			end
			if (events.is_rw && (!lines.ready_line ||
				(drive_select.side_select && !lines.double_sided_line))) begin
				next_cmd_res[pos_drive_not_prepared] = 1'b1;
			end
			if (events.beyond_last_sector) next_xfer_err[7] = 1'b1;
			if (events.id_crc_fault || events.data_crc_fault) next_xfer_err[5] = 1'b1;
			if (events.overrun) next_xfer_err[4] = 1'b1;
			if (events.sector_missing) next_xfer_err[2] = 1'b1;
			if (events.write_attempt && lines.write_protect_line) next_xfer_err[1] = 1'b1;
			if (events.id_sync_missing || events.data_sync_missing) next_xfer_err[0] = 1'b1;
			if (events.deleted_sector_seen) next_data_fld[6] = 1'b1;
			if (events.data_crc_fault) next_data_fld[5] = 1'b1;
			if (events.media_cyl_valid && events.media_cylinder != events.requested_cylinder) begin
				next_xfer_err[2] = 1'b1;
				next_data_fld[4] = 1'b1;
				if (events.media_cylinder == bad_cylinder_value) begin
					next_data_fld[1] = 1'b1;
				end
			end
			if (events.compare_equal_hit) next_data_fld[3] = 1'b1;
			if (events.compare_unmet) next_data_fld[2] = 1'b1;
			if (events.data_sync_missing) next_data_fld[0] = 1'b1;
			if (events.cmd_done || events.cmd_abort) begin
				if (events.cmd_abort) begin
					next_cmd_res[7:6] = term_ready_change;
				end else if (next_cmd_res[4:3] != 2'h0 || next_xfer_err != 8'h00 ||
					(next_data_fld[6:0] & 7'h33) != 7'h00) begin
					next_cmd_res[7:6] = term_abnormal;
				end else begin
					next_cmd_res[7:6] = term_normal;
				end
				if (events.is_seek || events.is_recal) begin
					next_cmd_res[pos_positioning_complete] = 1'b1;
				end
				if (events.is_recal && !lines.home_track_line &&
					(step_count == recal_step_limit)) begin
					next_cmd_res[pos_equipment_fault] = 1'b1;
					next_cmd_res[7:6] = term_abnormal;
				end
				next_cmd_res[2] = drive_select.side_select;
				next_cmd_res[1] = drive_select.unit_pick_high;
				next_cmd_res[0] = drive_select.unit_pick_low;
				next_result_ready = 1'b1;
				next_irq_event = 1'b1;
			end
		end
		next_xfer_err[6] = 1'b0;
		next_xfer_err[3] = 1'b0;
		next_data_fld[7] = 1'b0;
	end

	// Register read mux
	always_comb begin
		next_prdata = prdata;
		if (psel && !penable && !pwrite) begin
			unique case (paddr)
				addr_command_result: next_prdata = {24'h000000, cmd_res};
				addr_transfer_error: next_prdata = {24'h000000, xfer_err};
				addr_data_field: next_prdata = {24'h000000, data_fld};
				addr_drive_line: next_prdata = {24'h000000, lines, drive_select};
				addr_outcome_ctrl: next_prdata = {31'h00000000, result_ready};
				default: next_prdata = 32'h00000000;
			endcase
		end
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			cmd_res <= status_reset;
			xfer_err <= status_reset;
			data_fld <= status_reset;
			step_count <= '0;
			result_ready <= 1'b0;
			irq_event <= 1'b0;
			clear_req <= 1'b0;
			prdata <= 32'h00000000;
		end else begin
			cmd_res <= next_cmd_res;
			xfer_err <= next_xfer_err;
			data_fld <= next_data_fld;
			step_count <= next_step_count;
			result_ready <= next_result_ready;
			irq_event <= next_irq_event;
			clear_req <= next_clear_req;
			prdata <= next_prdata;
		end
	end
endmodule // disk_controller_result_status

// file: rtl/line_sync.sv
`timescale 1ns/1ps
module line_sync #(
	parameter int width = 8
) (
	input wire logic ref_clk,
	input wire logic nrst,
	input wire logic [width-1:0] raw,
	output logic [width-1:0] clean
);
	logic [width-1:0] s1, s2, s3, next_clean;

	always_comb begin
		next_clean = clean;
		for (int i = 0; i < width; i++) begin
			if (s2[i] == s3[i]) begin
				next_clean[i] = s2[i];
			end
		end
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			s1 <= '0;
			s2 <= '0;
			s3 <= '0;
			clean <= '0;
		end else begin
			s1 <= raw;
			s2 <= s1;
			s3 <= s2;
			clean <= next_clean;
		end
	end
endmodule // line_sync

// file: rtl/result_status_pkg.sv
package result_status_pkg;

	// APB word addresses of the four result registers and the result-ready control register
	localparam logic [7:0] addr_command_result = 8'h00;
	localparam logic [7:0] addr_transfer_error = 8'h04;
	localparam logic [7:0] addr_data_field = 8'h08;
	localparam logic [7:0] addr_drive_line = 8'h0c;
	localparam logic [7:0] addr_outcome_ctrl = 8'h10;

	// Termination codes
	localparam logic [1:0] term_normal = 2'h0;
	localparam logic [1:0] term_abnormal = 2'h1;
	localparam logic [1:0] term_invalid = 2'h2;
	localparam logic [1:0] term_ready_change = 2'h3;

	// Step pulses allowed before recalibration gives up
	localparam logic [6:0] recal_step_limit = 7'h4d;
	localparam logic [7:0] bad_cylinder_value = 8'hff;
	localparam logic [7:0] status_reset = 8'h00;

	// Bit positions
	localparam int pos_positioning_complete = 5;
	localparam int pos_equipment_fault = 4;
	localparam int pos_drive_not_prepared = 3;

	// Drive-facing lines
	typedef struct packed {
		logic drive_fault_line;
		logic write_protect_line;
		logic ready_line;
		logic home_track_line;
		logic double_sided_line;
	} drive_lines_t;

	// Controller outputs to the drive
	typedef struct packed {
		logic side_select;
		logic unit_pick_high;
		logic unit_pick_low;
	} drive_select_t;

	// Event pulses from the command sequencer
	typedef struct packed {
		logic cmd_start;
		logic cmd_invalid;
		logic cmd_done;
		logic cmd_abort;
		logic is_seek;
		logic is_recal;
		logic is_rw;
		logic recal_step;
		logic beyond_last_sector;
		logic id_crc_fault;
		logic data_crc_fault;
		logic overrun;
		logic sector_missing;
		logic media_cyl_valid;
		logic [7:0] media_cylinder;
		logic [7:0] requested_cylinder;
		logic write_attempt;
		logic id_sync_missing;
		logic data_sync_missing;
		logic deleted_sector_seen;
		logic compare_equal_hit;
		logic compare_unmet;
	} seq_events_t;

endpackage
